// *** rtl/sram_write_lane_mask.v ***
// Notes on behaviour
// - both lane selects low: whole word written
// - only lane-0 low: low lane written only
// - only lane-1 low: high lane written only, nothing in x9
// - both selects high: nothing written this beat
// - x9: one select governs all nine bits
// - capture and launch on both clock rises
// - each beat uses its own lane selects
// - power-up deselected, outputs high impedance
// - burst walks A, A+1, A+2, A+3
// - select after a start is don't-care
// - second same-type request directly after: ignored
// - write address at t, data t+2 to t+5
`timescale 1ns/1ns
`default_nettype none
`include "lane_sram_regs.vh"
module sram_write_lane_mask (
  input wire i_clk,
  input wire i_rst,
  input wire i_k,
  input wire i_k_n,
  input wire [1:0] i_org,
  input wire [`ADDR_W-1:0] i_addr,
  input wire i_read_port_select_n,
  input wire i_write_port_select_n,
  input wire [`DATA_W-1:0] i_d,
  input wire [1:0] i_byte_lane_write_select_n,
  output reg [`DATA_W-1:0] o_q,
  output reg o_q_oe_n,
  output reg o_wbuf_ready
);
  // ----------------------------------------
  // clock-pin rise detection
  // ----------------------------------------
  reg k_prev;
  reg kn_prev;
  wire k_rise;
  wire kn_rise;
  wire any_rise;

  assign k_rise = i_k & ~k_prev;
  assign kn_rise = i_k_n & ~kn_prev;
  assign any_rise = k_rise | kn_rise;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      k_prev <= 1'b1;
      kn_prev <= 1'b1;
    end else begin
      k_prev <= i_k;
      kn_prev <= i_k_n;
    end
  end

  // ----------------------------------------
  // port starts and arbitration
  // ----------------------------------------
  reg rd_prev;
  reg wr_prev;
  reg rd_slot;
  reg wr_slot;
  wire start_rd;
  wire start_wr;

  // a select that started a transfer at the last K rise is ignored now
  assign start_rd = k_rise & ~i_read_port_select_n & ~rd_prev;
  // shared address: read wins unless a read just started
  assign start_wr = k_rise & ~i_write_port_select_n & ~wr_prev & ~start_rd;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      rd_slot <= 1'b0;
      wr_slot <= 1'b0;
    end else if (k_rise) begin
      rd_prev <= start_rd;
      wr_prev <= start_wr;
      if (start_rd) begin
        rd_slot <= ~rd_slot;
      end
      if (start_wr) begin
        wr_slot <= ~wr_slot;
      end
    end
  end

  // ----------------------------------------
  // burst sequencers, two per port
  // ----------------------------------------
  // starts are at least two K rises apart, so two bursts in flight at most
  wire [1:0] wr_beat_s;
  wire [1:0] rd_beat_s;
  wire [`ADDR_W-1:0] wr_addr_s [0:1];
  wire [`ADDR_W-1:0] rd_addr_s [0:1];

  genvar si;
  generate
    for (si = 0; si < 2; si = si + 1) begin : g_slot
      burst_seq #(.FIRST(`WR_FIRST_EDGE)) u_wr (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_edge(any_rise),
        .i_start(start_wr && (wr_slot == si)),
        .i_addr(i_addr),
        .o_beat(wr_beat_s[si]),
        .o_beat_addr(wr_addr_s[si])
      );
      burst_seq #(.FIRST(`RD_FIRST_EDGE)) u_rd (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_edge(any_rise),
        .i_start(start_rd && (rd_slot == si)),
        .i_addr(i_addr),
        .o_beat(rd_beat_s[si]),
        .o_beat_addr(rd_addr_s[si])
      );
    end
  endgenerate

  wire wr_beat;
  wire rd_beat;
  wire [`ADDR_W-1:0] wr_beat_addr;
  wire [`ADDR_W-1:0] rd_beat_addr;

  assign wr_beat = |wr_beat_s;
  assign rd_beat = |rd_beat_s;
  assign wr_beat_addr = wr_beat_s[1] ? wr_addr_s[1] : wr_addr_s[0];
  assign rd_beat_addr = rd_beat_s[1] ? rd_addr_s[1] : rd_addr_s[0];

  // ----------------------------------------
  // lane mask of the current beat
  // ----------------------------------------
  reg [`DATA_W-1:0] beat_mask;

  always @* begin
    beat_mask = {`DATA_W{1'b0}};
    case (i_org)
      `ORG_X8: begin
        if (!i_byte_lane_write_select_n[0]) begin
          beat_mask = beat_mask | `X8_LO_MASK;
        end
        if (!i_byte_lane_write_select_n[1]) begin
          beat_mask = beat_mask | `X8_HI_MASK;
        end
      end
      `ORG_X9: begin
        if (!i_byte_lane_write_select_n[0]) begin
          beat_mask = `X9_MASK;
        end
      end
      `ORG_X18: begin
        if (!i_byte_lane_write_select_n[0]) begin
          beat_mask = beat_mask | `X18_LO_MASK;
        end
        if (!i_byte_lane_write_select_n[1]) begin
          beat_mask = beat_mask | `X18_HI_MASK;
        end
      end
      default: begin
        beat_mask = {`DATA_W{1'b0}};
      end
    endcase
  end

  // ----------------------------------------
  // two-entry write buffer
  // ----------------------------------------
  // the array has one port; a read beat takes it and stalls the drain
  reg [`DATA_W-1:0] buf_data [0:1];
  reg [`DATA_W-1:0] buf_mask [0:1];
  reg [`ADDR_W-1:0] buf_addr [0:1];
  reg buf_wptr;
  reg buf_rptr;
  reg [1:0] buf_count;
  reg [1:0] next_count;
  wire push;
  wire pop;

  // an all-high beat pushes nothing, so memory stays untouched
  assign push = wr_beat && (beat_mask != {`DATA_W{1'b0}}) && o_wbuf_ready;
  assign pop = (buf_count != 2'h0) && !rd_beat;

  always @* begin
    next_count = buf_count;
    if (push && !pop) begin
      next_count = buf_count + 2'h1;
    end else if (pop && !push) begin
      next_count = buf_count - 2'h1;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_wptr <= 1'b0;
      buf_rptr <= 1'b0;
      buf_count <= 2'h0;
      o_wbuf_ready <= 1'b1;
    end else begin
      buf_count <= next_count;
      o_wbuf_ready <= (next_count != 2'h2);
      if (push) begin
        buf_wptr <= ~buf_wptr;
      end
      if (pop) begin
        buf_rptr <= ~buf_rptr;
      end
    end
  end

  always @(posedge i_clk) begin
    if (push) begin
      buf_data[buf_wptr] <= i_d;
      buf_mask[buf_wptr] <= beat_mask;
      buf_addr[buf_wptr] <= wr_beat_addr;
    end
  end

  // ----------------------------------------
  // storage array
  // ----------------------------------------
  reg [`DATA_W-1:0] mem [0:`DEPTH-1];
  wire [`DATA_W-1:0] pop_data;
  wire [`DATA_W-1:0] pop_mask;
  wire [`ADDR_W-1:0] pop_addr;

  assign pop_data = buf_data[buf_rptr];
  assign pop_mask = buf_mask[buf_rptr];
  assign pop_addr = buf_addr[buf_rptr];

  genvar mi;
  generate
    for (mi = 0; mi < `DEPTH; mi = mi + 1) begin : g_word
      always @(posedge i_clk) begin
        if (pop && pop_addr == mi) begin
          // unselected lanes keep their stored bits
          mem[mi] <= (mem[mi] & ~pop_mask) | (pop_data & pop_mask);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // read launch
  // ----------------------------------------
  // limitation: a word still in the buffer is not forwarded to reads
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= {`DATA_W{1'b0}};
      o_q_oe_n <= 1'b1;
    end else if (rd_beat) begin
      o_q <= mem[rd_beat_addr];
      o_q_oe_n <= 1'b0;
    end else if (any_rise) begin
      o_q_oe_n <= 1'b1;
    end
  end
endmodule // sram_write_lane_mask
`default_nettype wire

// *** rtl/lane_sram_regs.vh ***
`ifndef LANE_SRAM_REGS_VH
`define LANE_SRAM_REGS_VH
// ----------------------------------------
// word layout and array size
// ----------------------------------------
`define DATA_W 18
`define ADDR_W 4
`define DEPTH 16
// ----------------------------------------
// organisations
// ----------------------------------------
`define ORG_X8 2'h0
`define ORG_X9 2'h1
`define ORG_X18 2'h2
// ----------------------------------------
// lane boundaries
// ----------------------------------------
`define X8_LO_MASK 18'h0000f
`define X8_HI_MASK 18'h000f0
`define X18_LO_MASK 18'h001ff
`define X18_HI_MASK 18'h3fe00
`define X9_MASK 18'h001ff
// ----------------------------------------
// burst timing in clock-pin rises: first beat after the address rise, last beat after the first
// ----------------------------------------
`define WR_FIRST_EDGE 4'h2
`define RD_FIRST_EDGE 4'h5
`define BURST_LAST 4'h3
`endif

// *** rtl/burst_seq.v ***
`timescale 1ns/1ns
`default_nettype none
`include "lane_sram_regs.vh"
module burst_seq #(
  parameter [3:0] FIRST = 4'h2
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_edge,
  input wire i_start,
  input wire [`ADDR_W-1:0] i_addr,
  output wire o_beat,
  output wire [`ADDR_W-1:0] o_beat_addr
);
  // ----------------------------------------
  // edge counter: number of the next clock-pin rise
  // ----------------------------------------
  reg [3:0] cnt;
  reg [`ADDR_W-1:0] base;
  wire [3:0] offset;
  wire [3:0] last;

  assign last = FIRST + `BURST_LAST;
  assign offset = cnt - FIRST;
  assign o_beat = i_edge && (cnt >= FIRST) && (cnt <= last);
  // latched address first, then the three following locations
  assign o_beat_addr = base + {{(`ADDR_W-2){1'b0}}, offset[1:0]};

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 4'h0;
      base <= {`ADDR_W{1'b0}};
    end else if (i_start) begin
      cnt <= 4'h1;
      base <= i_addr;
    end else if (i_edge && cnt != 4'h0) begin
      if (cnt == last) begin
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // burst_seq
`default_nettype wire

// *** bench/k_pin_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// master clock pins
// ----
module k_pin_gen (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_k,
  output logic o_k_n,
  output logic [1:0] o_ph
);
  // rises two cycles apart, never in one cycle
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ph <= 2'h3;
      o_k <= 1'b1;
      o_k_n <= 1'b1;
    end else begin
      o_ph <= o_ph + 2'h1;
      o_k <= (o_ph == 2'h3);
      o_k_n <= (o_ph == 2'h1);
    end
  end
endmodule // k_pin_gen
`default_nettype wire

// *** bench/lane_mask_chk_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lane_sram_regs.vh"
// ----
// port checker
// ----
module lane_mask_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_read_port_select_n,
  input wire logic [`DATA_W-1:0] o_q,
  input wire logic o_q_oe_n,
  input wire logic o_wbuf_ready
);
  logic k_d;
  logic kn_d;
  wire rise = (i_k & ~k_d) | (i_k_n & ~kn_d);
  wire rd_go = i_k & ~k_d & ~i_read_port_select_n;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      k_d <= 1'b1;
      kn_d <= 1'b1;
    end else begin
      k_d <= i_k;
      kn_d <= i_k_n;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_quiet; o_q_oe_n [*8]; endsequence
  sequence s_drive; !o_q_oe_n [*8]; endsequence
  property p_rst; $fell(i_rst) |-> o_q_oe_n && o_wbuf_ready && o_q == 18'h0; endproperty
  property p_lat; rd_go && o_q_oe_n |-> ##1 s_quiet ##3 s_drive ##1 o_q_oe_n; endproperty
  property p_four; $fell(o_q_oe_n) |-> s_drive ##1 o_q_oe_n; endproperty
  property p_fell; $fell(o_q_oe_n) |-> $past(rise); endproperty
  property p_qrise; !$stable(o_q) |-> $past(rise); endproperty
  property p_qdrv; !$stable(o_q) |-> !o_q_oe_n; endproperty
  property p_hold; !o_q_oe_n && !rise |=> !o_q_oe_n; endproperty
  property p_wbuf; $fell(o_wbuf_ready) |-> $past(rise); endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  a_lat: assert property (p_lat) else $error("bad read timing");
  a_four: assert property (p_four) else $error("burst not four");
  a_fell: assert property (p_fell) else $error("drive off rise");
  a_qrise: assert property (p_qrise) else $error("q off rise");
  a_qdrv: assert property (p_qdrv) else $error("q while hiz");
  a_hold: assert property (p_hold) else $error("drive dropped");
  a_wbuf: assert property (p_wbuf) else $error("push off rise");
endmodule // lane_mask_chk
bind sram_write_lane_mask lane_mask_chk chk (.i_clk(i_clk), .i_rst(i_rst), .i_k(i_k),
  .i_k_n(i_k_n), .i_read_port_select_n(i_read_port_select_n), .o_q(o_q),
  .o_q_oe_n(o_q_oe_n), .o_wbuf_ready(o_wbuf_ready));
`default_nettype wire

// *** bench/sram_write_lane_mask_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lane_sram_regs.vh"
// ----
// bench
// ----
module sram_write_lane_mask_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] org = 2'h0;
  logic [3:0] addr = 4'h0;
  logic rps_n = 1'b1;
  logic wps_n = 1'b1;
  logic [17:0] d = 18'h0;
  logic [1:0] sel_n = 2'h3;
  wire k;
  wire k_n;
  wire [1:0] ph;
  wire [17:0] q;
  wire oe_n;
  wire wrdy;
  logic [17:0] m [0:15];
  int bad_count = 0;
  int checks_done = 0;
  always #20 i_clk = ~i_clk;
  k_pin_gen mst (.i_clk(i_clk), .i_rst(i_rst), .o_k(k), .o_k_n(k_n), .o_ph(ph));
  sram_write_lane_mask dut (.i_clk(i_clk), .i_rst(i_rst), .i_k(k), .i_k_n(k_n),
    .i_org(org), .i_addr(addr), .i_read_port_select_n(rps_n),
    .i_write_port_select_n(wps_n), .i_d(d), .i_byte_lane_write_select_n(sel_n),
    .o_q(q), .o_q_oe_n(oe_n), .o_wbuf_ready(wrdy));
  function automatic logic [17:0] lm(input logic [1:0] o, input logic [1:0] s);
    case (o)
      2'h0: lm = (s[0] ? 18'h0 : `X8_LO_MASK) | (s[1] ? 18'h0 : `X8_HI_MASK);
      2'h1: lm = s[0] ? 18'h0 : `X9_MASK;
      2'h2: lm = (s[0] ? 18'h0 : `X18_LO_MASK) | (s[1] ? 18'h0 : `X18_HI_MASK);
      default: lm = 18'h0;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // waits for the edge that opens rise r; odd rises are on the complement pin
  task automatic rise(input int r);
    do @(posedge i_clk); while (ph !== (r[0] ? 2'h1 : 2'h3));
  endtask
  task automatic wr(input logic [3:0] a, input logic [17:0] b, input logic [7:0] s,
      input logic dup);
    rise(0);
    wps_n <= 1'b0;
    addr <= a;
    for (int r = 1; r < 6; r++) begin
      rise(r);
      if (r == 1) wps_n <= ~dup;
      if (r == 1) addr <= a ^ 4'h8;
      if (r == 3) wps_n <= 1'b1;
      if (r > 1) begin
        d <= b + r;
        sel_n <= s[2*(r-2) +: 2];
        m[4'(a+r-2)] = (m[4'(a+r-2)] & ~lm(org, s[2*(r-2) +: 2]))
          | ((b + r) & lm(org, s[2*(r-2) +: 2]));
      end
    end
  endtask
  task automatic rd(input logic [3:0] a);
    rise(0);
    rps_n <= 1'b0;
    addr <= a;
    for (int r = 1; r < 10; r++) begin
      rise(r);
      rps_n <= 1'b1;
      if (r > 4) begin
        @(posedge i_clk);
        #1;
        chk("o_q_oe_n", {17'h0, r == 9}, oe_n);
        if (r < 9) chk("o_q", m[4'(a+r-5)] & lm(org, 2'h0), q & lm(org, 2'h0));
        chk("o_wbuf_ready", 18'h1, {17'h0, wrdy});
      end
    end
  endtask
  // both, low, high, none lanes across one burst
  task automatic t_org(input logic [1:0] o);
    org <= o;
    wr(4'h4, 18'h15555, 8'h00, 1'b0);
    wr(4'h4, 18'h2aaaa, 8'hd8, 1'b0);
    rd(4'h4);
    $display("lane test org %0d done", o);
  endtask
  task automatic t_dup;
    org <= 2'h2;
    wr(4'hc, 18'h01234, 8'h00, 1'b0);
    wr(4'h4, 18'h3c3c3, 8'h00, 1'b1);
    rd(4'hc);
    $display("repeat start test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("o_q_oe_n", 18'h1, {17'h0, oe_n});
    chk("o_wbuf_ready", 18'h1, {17'h0, wrdy});
    chk("o_q", 18'h0, q);
    t_org(2'h0);
    t_org(2'h1);
    t_org(2'h2);
    t_dup;
    end_of_test;
  end
  // whole run needs some 185 cycles
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
endmodule // sram_write_lane_mask_tb
`default_nettype wire
